// File: inc/char_lcd_pkg.sv
package char_lcd_pkg;
	localparam int CLK_HZ = 25000000;
	localparam int LONG_EXEC_NS = 1520000;
	localparam int SHORT_EXEC_NS = 38000;
	localparam int LONG_EXEC_CYC = (CLK_HZ / 1000) * (LONG_EXEC_NS / 1000) / 1000;
	localparam int SHORT_EXEC_CYC = (CLK_HZ / 1000) * (SHORT_EXEC_NS / 1000) / 1000;
	localparam int BUSY_W = 16;
	localparam int DISP_DEPTH = 128;
	localparam int GLYPH_DEPTH = 64;
	localparam logic [7:0] SPACE_CODE = 8'h20;
	localparam logic [6:0] HOME_ADDR = 7'h00;
	localparam logic [6:0] LINE2_BASE = 7'h40;
	localparam logic [6:0] LINE_LEN = 7'h10;
	localparam logic [7:0] POWERON_FUNC = 8'h30;
	localparam logic [7:0] POWERON_DISP = 8'h08;
	localparam logic [7:0] POWERON_ENTRY = 8'h06;
	typedef enum logic [2:0] {
		OP_NONE = 3'b000,
		OP_CLEAR = 3'b001,
		OP_HOME = 3'b010,
		OP_ENTRY = 3'b011,
		OP_DISP = 3'b100,
		OP_SHIFT = 3'b101,
		OP_FUNC = 3'b110,
		OP_ADDR = 3'b111
	} op_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_CLEAR = 3'b001,
		ST_WAIT = 3'b010,
		ST_INIT_FUNC = 3'b011,
		ST_INIT_DISP = 3'b100,
		ST_INIT_ENTRY = 3'b101
	} state_t;
endpackage

// File: src/char_lcd_instruction_decoder.sv
`timescale 1ns/1ns
module char_lcd_instruction_decoder
	import char_lcd_pkg::*;
#(
	parameter int LONG_CYC = LONG_EXEC_CYC,
	parameter int SHORT_CYC = SHORT_EXEC_CYC
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic register_select,
	input wire logic read_not_write,
	input wire logic enable,
	input wire logic [7:0] data_in,
	output logic [7:0] data_out,
	output logic data_oe,
	output logic busy_flag,
	output logic [6:0] address_counter,
	output logic display_on,
	output logic cursor_on,
	output logic blink_on,
	output logic bus_width_select,
	output logic two_lines,
	output logic big_font,
	output logic [6:0] display_offset,
	input wire logic [6:0] view_addr,
	output logic [7:0] view_data
);
	logic [10:0] pins_s;
	logic sel_s;
	logic rnw_s;
	logic en_s;
	logic en_d_r;
	logic [7:0] din_s;
	logic [7:0] display_ram [DISP_DEPTH];
	logic [7:0] glyph_ram [GLYPH_DEPTH];
	logic glyph_sel_r;
	logic step_inc_r;
	logic shift_on_access_r;
	logic [BUSY_W-1:0] busy_cnt_r;
	state_t state_r;
	logic [6:0] clear_idx_r;
	logic nibble_low_r;
	logic [3:0] hi_nib_r;
	logic en_fall;
	logic en_rise;
	logic [7:0] wr_byte;
	logic wr_done;
	logic rd_done;
	logic [7:0] instr;
	logic instr_go;
	logic [7:0] rd_byte;

	pin_sync #(
		.WIDTH(11)
	) u_sync (
		.clk_sys(clk_sys),
		.rst(rst),
		.async_in({register_select, read_not_write, enable, data_in}),
		.sync_out(pins_s)
	);
	assign sel_s = pins_s[10];
	assign rnw_s = pins_s[9];
	assign en_s = pins_s[8];
	assign din_s = pins_s[7:0];

	function automatic op_t decode(input logic [7:0] b);
		if (b[7]) begin
			decode = OP_ADDR;
		end else if (b[6]) begin
			decode = OP_ADDR;
		end else if (b[5]) begin
			decode = OP_FUNC;
		end else if (b[4]) begin
			decode = OP_SHIFT;
		end else if (b[3]) begin
			decode = OP_DISP;
		end else if (b[2]) begin
			decode = OP_ENTRY;
		end else if (b[1]) begin
			decode = OP_HOME;
		end else if (b[0]) begin
			decode = OP_CLEAR;
		end else begin
			decode = OP_NONE;
		end
	endfunction

	function automatic logic [6:0] step(input logic [6:0] a, input logic inc);
		if (inc) begin
			step = 7'(a + 7'h01);
		end else begin
			step = 7'(a - 7'h01);
		end
	endfunction

	// Glyph addresses wrap inside their own smaller space instead of spilling into display addresses.
	function automatic logic [6:0] next_addr(input logic [6:0] a, input logic inc, input logic glyph);
		if (glyph) begin
			next_addr = step(a, inc) & 7'(GLYPH_DEPTH - 1);
		end else begin
			next_addr = step(a, inc);
		end
	endfunction

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			en_d_r <= 1'b0;
		end else begin
			en_d_r <= en_s;
		end
	end
	assign en_fall = en_d_r & ~en_s;
	assign en_rise = ~en_d_r & en_s;

	// Nibble pairing: the first transfer is the high half, the second the low.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			nibble_low_r <= 1'b0;
			hi_nib_r <= 4'h0;
		end else if (en_fall && !bus_width_select) begin
			nibble_low_r <= ~nibble_low_r;
			if (!nibble_low_r) begin
				hi_nib_r <= din_s[7:4];
			end
		end else if (bus_width_select) begin
			nibble_low_r <= 1'b0;
		end
	end

	// Writes are taken on the falling edge of enable.
	assign wr_done = en_fall && !rnw_s && (bus_width_select || nibble_low_r);
	assign wr_byte = bus_width_select ? din_s : {hi_nib_r, din_s[7:4]};
	assign rd_done = en_fall && rnw_s && (bus_width_select || nibble_low_r);
	// Writes arriving while busy are ignored; the host must wait.
	assign instr_go = wr_done && !sel_s && state_r == ST_IDLE;
	assign instr = wr_byte;

	// Read path: status or RAM, output latched at enable rise.
	always_comb begin
		if (!sel_s) begin
			rd_byte = {busy_flag, address_counter};
		end else if (glyph_sel_r) begin
			rd_byte = glyph_ram[address_counter[5:0]];
		end else begin
			rd_byte = display_ram[address_counter];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			data_out <= 8'h00;
			data_oe <= 1'b0;
		end else begin
			if (en_rise && rnw_s) begin
				// The whole byte is latched once, so both halves of a split read belong together.
				if (bus_width_select || !nibble_low_r) begin
					data_out <= rd_byte;
				end else begin
					data_out <= {data_out[3:0], 4'h0};
				end
			end
			data_oe <= en_s && rnw_s;
		end
	end

	assign busy_flag = state_r != ST_IDLE;

	// Main sequencer: power-on sequence, clearing sweep and execution timer.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_r <= ST_INIT_FUNC;
			busy_cnt_r <= '0;
			clear_idx_r <= HOME_ADDR;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (instr_go && decode(instr) == OP_CLEAR) begin
						state_r <= ST_CLEAR;
						clear_idx_r <= HOME_ADDR;
						busy_cnt_r <= BUSY_W'(LONG_CYC);
					end else if (instr_go && decode(instr) == OP_HOME) begin
						state_r <= ST_WAIT;
						busy_cnt_r <= BUSY_W'(LONG_CYC);
					end else if (instr_go || (wr_done && sel_s) || (rd_done && sel_s)) begin
						state_r <= ST_WAIT;
						busy_cnt_r <= BUSY_W'(SHORT_CYC);
					end
				end
				ST_CLEAR: begin
					// A long count shorter than the sweep must not wrap the timer.
					if (busy_cnt_r != '0) begin
						busy_cnt_r <= busy_cnt_r - 1'b1;
					end
					clear_idx_r <= 7'(clear_idx_r + 7'h01);
					if (clear_idx_r == 7'(DISP_DEPTH - 1)) begin
						state_r <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					busy_cnt_r <= busy_cnt_r - 1'b1;
					if (busy_cnt_r <= BUSY_W'(1)) begin
						state_r <= ST_IDLE;
					end
				end
				ST_INIT_FUNC: begin
					state_r <= ST_INIT_DISP;
				end
				ST_INIT_DISP: begin
					state_r <= ST_INIT_ENTRY;
				end
				ST_INIT_ENTRY: begin
					state_r <= ST_CLEAR;
					clear_idx_r <= HOME_ADDR;
					busy_cnt_r <= BUSY_W'(LONG_CYC);
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// Configuration registers.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			display_on <= 1'b0;
			cursor_on <= 1'b0;
			blink_on <= 1'b0;
			bus_width_select <= 1'b1;
			two_lines <= 1'b0;
			big_font <= 1'b0;
			step_inc_r <= 1'b1;
			shift_on_access_r <= 1'b0;
		end else if (state_r == ST_INIT_FUNC) begin
			{bus_width_select, two_lines, big_font} <= POWERON_FUNC[4:2];
		end else if (state_r == ST_INIT_DISP) begin
			{display_on, cursor_on, blink_on} <= POWERON_DISP[2:0];
		end else if (state_r == ST_INIT_ENTRY) begin
			{step_inc_r, shift_on_access_r} <= POWERON_ENTRY[1:0];
		end else if (instr_go) begin
			case (decode(instr))
				OP_ENTRY: begin
					{step_inc_r, shift_on_access_r} <= instr[1:0];
				end
				OP_DISP: begin
					{display_on, cursor_on, blink_on} <= instr[2:0];
				end
				OP_FUNC: begin
					{bus_width_select, two_lines, big_font} <= instr[4:2];
				end
				default: ;
			endcase
		end
	end

	// Address counter, RAM select and display shift.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			address_counter <= HOME_ADDR;
			glyph_sel_r <= 1'b0;
			display_offset <= HOME_ADDR;
		end else if (state_r == ST_CLEAR && clear_idx_r == HOME_ADDR) begin
			address_counter <= HOME_ADDR;
			glyph_sel_r <= 1'b0;
			display_offset <= HOME_ADDR;
		end else if (instr_go) begin
			case (decode(instr))
				OP_HOME: begin
					address_counter <= HOME_ADDR;
					glyph_sel_r <= 1'b0;
					display_offset <= HOME_ADDR;
				end
				OP_SHIFT: begin
					if (instr[3]) begin
						display_offset <= step(display_offset, ~instr[2]);
					end else begin
						address_counter <= next_addr(address_counter, instr[2], glyph_sel_r);
					end
				end
				OP_ADDR: begin
					glyph_sel_r <= ~instr[7];
					if (instr[7]) begin
						address_counter <= instr[6:0];
					end else begin
						address_counter <= {1'b0, instr[5:0]};
					end
				end
				default: ;
			endcase
		end else if ((wr_done || rd_done) && sel_s && state_r == ST_IDLE) begin
			address_counter <= next_addr(address_counter, step_inc_r, glyph_sel_r);
			// Reads leave the view alone, so polling the RAM never scrolls the display.
			if (shift_on_access_r && wr_done) begin
				display_offset <= step(display_offset, ~step_inc_r);
			end
		end
	end

	// RAM storage; clearing sweeps one location per clock.
	always_ff @(posedge clk_sys) begin
		if (state_r == ST_CLEAR) begin
			display_ram[clear_idx_r] <= SPACE_CODE;
		end else if (wr_done && sel_s && state_r == ST_IDLE) begin
			if (glyph_sel_r) begin
				glyph_ram[address_counter[5:0]] <= wr_byte;
			end else begin
				display_ram[address_counter] <= wr_byte;
			end
		end
	end

	// The view port is a separate read port, so screen refresh never waits on the host.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			view_data <= 8'h00;
		end else begin
			view_data <= display_ram[view_addr];
		end
	end
endmodule

// File: src/pin_sync.sv
`timescale 1ns/1ns
module pin_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_r;

	// The first stage is read only by the second stage.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			meta_r <= '0;
			sync_out <= '0;
		end else begin
			meta_r <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule

// File: tb/char_lcd_instruction_decoder_bench.sv
`timescale 1ns/1ns
module char_lcd_instruction_decoder_bench;
	logic clk_sys, rst, register_select, read_not_write, enable, data_oe, busy_flag;
	logic display_on, cursor_on, blink_on, bus_width_select, two_lines, big_font;
	logic [7:0] data_in, data_out, view_data, q;
	logic [6:0] address_counter, display_offset, view_addr;
	int n_errors = 0;
	int checks = 0;
	char_lcd_instruction_decoder #(.LONG_CYC(20), .SHORT_CYC(5)) i_dut (.*);
	lcd_host_model i_host (.*);
	task automatic end_of_test;
		if (n_errors == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic ready;
		int i;
		for (i = 0; i < 300 && busy_flag !== 1'b0; i++) begin
			@(posedge clk_sys);
			#1;
		end
		if (i == 300) begin
			chk("busy wait", 8'h00, 8'h01);
			end_of_test();
		end
	endtask
	task automatic op(input logic rs, input logic [7:0] d);
		i_host.xfer(rs, 1'b0, d, q);
		ready();
	endtask
	task automatic rd(input logic rs);
		i_host.xfer(rs, 1'b1, 8'h00, q);
		ready();
	endtask
	task automatic view(input logic [6:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		view_addr <= a;
		repeat (2) @(posedge clk_sys);
		#1 chk("view_data", e, view_data);
	endtask
	task automatic t_reset;
		ready();
		chk("address_counter", 8'h00, {1'b0, address_counter});
		chk("bus_width_select", 8'h01, {7'h00, bus_width_select});
		view(7'h00, 8'h20);
	endtask
	task automatic t_ram;
		op(1'b0, 8'hC5);
		chk("address_counter", 8'h45, {1'b0, address_counter});
		op(1'b1, 8'h41);
		op(1'b1, 8'h42);
		chk("address_counter", 8'h47, {1'b0, address_counter});
		view(7'h46, 8'h42);
		op(1'b0, 8'hC5);
		rd(1'b1);
		chk("data read", 8'h41, q);
		rd(1'b0);
		chk("status read", 8'h46, q);
	endtask
	task automatic t_modes;
		logic [7:0] dc [3] = '{8'h0C, 8'h0A, 8'h09};
		op(1'b0, 8'h04);
		op(1'b0, 8'h90);
		op(1'b1, 8'h55);
		chk("address_counter", 8'h0F, {1'b0, address_counter});
		op(1'b0, 8'h06);
		foreach (dc[k]) begin
			op(1'b0, dc[k]);
			chk("display control", {5'h00, dc[k][2:0]}, {5'h00, display_on, cursor_on, blink_on});
		end
		op(1'b0, 8'h3F);
		chk("function set", 8'h07, {5'h00, bus_width_select, two_lines, big_font});
		op(1'b0, 8'h38);
		chk("function set", 8'h06, {5'h00, bus_width_select, two_lines, big_font});
	endtask
	task automatic t_shift_home;
		op(1'b0, 8'h80);
		op(1'b0, 8'h14);
		chk("address_counter", 8'h01, {1'b0, address_counter});
		op(1'b0, 8'h10);
		op(1'b0, 8'h18);
		chk("address_counter", 8'h00, {1'b0, address_counter});
		op(1'b0, 8'h02);
		chk("display_offset", 8'h00, {1'b0, display_offset});
		view(7'h45, 8'h41);
		op(1'b0, 8'h07);
		op(1'b1, 8'h33);
		chk("display_offset", 8'h7F, {1'b0, display_offset});
		op(1'b0, 8'h06);
	endtask
	task automatic t_glyph_clear;
		op(1'b0, 8'h45);
		chk("address_counter", 8'h05, {1'b0, address_counter});
		op(1'b1, 8'hAA);
		op(1'b0, 8'h45);
		rd(1'b1);
		chk("glyph read", 8'hAA, q);
		op(1'b0, 8'h01);
		chk("address_counter", 8'h00, {1'b0, address_counter});
		view(7'h45, 8'h20);
	endtask
	task automatic t_nibble;
		op(1'b0, 8'h28);
		chk("bus_width_select", 8'h00, {7'h00, bus_width_select});
		op(1'b0, 8'hC0);
		op(1'b0, 8'h50);
		chk("address_counter", 8'h45, {1'b0, address_counter});
		rd(1'b0);
		chk("status high nibble", 8'h04, {4'h0, q[7:4]});
		rd(1'b0);
		chk("status low nibble", 8'h05, {4'h0, q[7:4]});
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	initial begin
		rst = 1'b1;
		view_addr = 7'h00;
		repeat (10) @(posedge clk_sys);
		rst <= 1'b0;
		t_reset();
		t_ram();
		t_modes();
		t_shift_home();
		t_glyph_clear();
		t_nibble();
		end_of_test();
	end
endmodule

// File: tb/lcd_chk.sv
`timescale 1ns/1ns
module lcd_chk
	import char_lcd_pkg::*;
#(
	parameter int LONG_CYC = 20,
	parameter int SHORT_CYC = 5
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic register_select,
	input wire logic read_not_write,
	input wire logic enable,
	input wire logic data_oe,
	input wire logic busy_flag,
	input wire logic bus_width_select,
	input wire logic [6:0] address_counter,
	input wire logic display_on,
	input wire logic cursor_on,
	input wire logic blink_on
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	int run;
	// The upper bound allows for the clear sweep, which outlasts a shortened long count.
	always_ff @(posedge clk_sys) begin
		if (rst || !busy_flag) run <= 0;
		else run <= run + 1;
	end
	a_busy_min_len: assert property ($fell(busy_flag) |-> run >= SHORT_CYC - 1)
		else $error("busy ended too early");
	a_busy_max_len: assert property (busy_flag |-> run <= LONG_CYC + DISP_DEPTH + 8)
		else $error("busy lasted too long");
	a_oe_needs_read: assert property (data_oe |-> ($past(enable, 2) || $past(enable, 3)) && $past(read_not_write, 3))
		else $error("bus driven outside a read");
	a_oe_on_read: assert property (enable && read_not_write [*4] |-> data_oe)
		else $error("bus not driven during a read");
	a_oe_released: assert property (!enable [*4] |-> !data_oe)
		else $error("bus still driven after enable low");
	a_write_sets_busy: assert property ($fell(enable) && !read_not_write && !busy_flag && bus_width_select
		|-> ##[2:5] busy_flag)
		else $error("accepted write did not set busy");
	a_status_no_busy: assert property ($fell(enable) && read_not_write && !register_select && !busy_flag
		|=> !busy_flag [*6])
		else $error("status read raised busy");
	a_ac_moves_busy: assert property ($changed(address_counter) |-> (##[0:1] busy_flag) or $past(busy_flag))
		else $error("address counter moved without an operation");
	a_ctrl_by_instr: assert property ($changed({display_on, cursor_on, blink_on}) |-> ##[0:1] busy_flag)
		else $error("display control changed without an instruction");
	c_status_read: cover property (enable && read_not_write && !register_select);
	c_data_write: cover property ($fell(enable) && register_select && !read_not_write);
	c_long_busy: cover property (run == LONG_CYC);
endmodule
bind char_lcd_instruction_decoder lcd_chk #(.LONG_CYC(LONG_CYC), .SHORT_CYC(SHORT_CYC)) i_chk (.*);

// File: tb/lcd_host_model.sv
`timescale 1ns/1ns
module lcd_host_model (
	input wire logic clk_sys,
	input wire logic [7:0] data_out,
	input wire logic data_oe,
	output logic register_select,
	output logic read_not_write,
	output logic enable,
	output logic [7:0] data_in
);
	logic [7:0] drv;
	logic own;
	// A released bus shows the inverse of the last value, so a stale copy never passes.
	assign data_in = own ? drv : (data_oe ? data_out : ~drv);
	initial begin
		{register_select, read_not_write, enable, own, drv} = '0;
	end
	// Every level is held well past the two-clock synchroniser lag.
	task automatic xfer(input logic rs, input logic rw, input logic [7:0] d, output logic [7:0] q);
		@(posedge clk_sys);
		register_select <= rs;
		read_not_write <= rw;
		drv <= d;
		own <= !rw;
		repeat (2) @(posedge clk_sys);
		enable <= 1'b1;
		repeat (6) @(posedge clk_sys);
		q = data_out;
		enable <= 1'b0;
		repeat (5) @(posedge clk_sys);
		own <= 1'b0;
	endtask
endmodule
